// [verilog/light_sensor_defines.svh]
// offsets, field positions, reset values and timing counts
`ifndef LIGHT_SENSOR_DEFINES_SVH
`define LIGHT_SENSOR_DEFINES_SVH

// ----------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------
`define OFF_RESULT    8'h00
`define OFF_CFG       8'h01

// ----------------------------------------------------------------
// measurement_control fields
// ----------------------------------------------------------------
`define CFG_RN_MSB    15
`define CFG_RN_LSB    12
`define CFG_CT        11
`define CFG_M_MSB     10
`define CFG_M_LSB     9
`define CFG_OVF       8
`define CFG_CRF       7
`define CFG_FH        6
`define CFG_FL        5
`define CFG_AUX_MSB   4
`define CFG_AUX_LSB   0
`define CFG_ME        2
`define CFG_RESET     16'hc810

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define RN_AUTO       4'hc
`define RN_MAX        4'hb
`define RN_STEPDOWN   12'h400
`define MODE_SHUT     2'h0
`define MODE_SINGLE   2'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ       25000
`define T_SHORT_MS    100
`define T_LONG_MS     800
`define T_SHORT_CYC   (`T_SHORT_MS * `CLK_KHZ)
`define T_LONG_CYC    (`T_LONG_MS * `CLK_KHZ)
`define TMR_W         25
`define SLAVE_ADDR    7'h2a

`endif

// [verilog/light_sensor_pkg.sv]
// shared types of the light sensor conversion control
package light_sensor_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  ptr;
    logic [15:0] data;
  } reg_req_s;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } conv_state_e;

  typedef enum logic [2:0] {
    SI_IDLE = 3'b000,
    SI_RX   = 3'b001,
    SI_ACKW = 3'b011,
    SI_ACK  = 3'b010,
    SI_TX   = 3'b110,
    SI_RACK = 3'b111
  } ser_state_e;

endpackage

// [verilog/conv_timer.sv]
// conversion length timer, restartable
`timescale 1ns/1ps
module conv_timer
  import light_sensor_pkg::*;
#(
  parameter int unsigned SHORT_CYC = 2500000,
  parameter int unsigned LONG_CYC  = 20000000,
  parameter int unsigned CW        = 25
)
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // control
  input  wire logic restart,
  input  wire logic run,
  input  wire logic long_sel,
  // event
  output      logic done
);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] limit;

  assign limit = long_sel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= '0;
      done    <= 1'b0;
    end
    else if (restart || !run)
    begin
      cnt_reg <= '0;
      done    <= 1'b0;
    end
    else if (cnt_reg >= limit)
    begin
      cnt_reg <= '0;
      done    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + CW'(1);
      done    <= 1'b0;
    end
  end

endmodule

// [verilog/serial_slave.sv]
// two-wire serial slave, oversampled by the system clock
`timescale 1ns/1ps
module serial_slave
  import light_sensor_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h2a
)
(
  // clock and reset
  input  wire logic     clk_sys,
  input  wire logic     nrst,
  // bus pins
  input  wire logic     scl_in,
  input  wire logic     sda_in,
  output      logic     sda_out,
  output      logic     sda_oe,
  // register side
  output      reg_req_s req,
  input  wire logic [15:0] rd_data
);

  logic [2:0]  scl_sync;
  logic [2:0]  sda_sync;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  byte_in;
  ser_state_e  st_reg;
  logic [2:0]  bitc_reg;
  logic [6:0]  sh_reg;
  logic [1:0]  idx_reg;
  logic        rw_reg;
  logic        hi_reg;
  logic [15:0] word_reg;
  logic [7:0]  tx_reg;

  // ----------------------------------------------------------------
  // pin synchronisers; stage 0 feeds stage 1 only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_sync[2];
  assign scl_fall = ~scl_sync[1] & scl_sync[2];
  assign start_c  = scl_sync[1] & sda_sync[2] & ~sda_sync[1];
  assign stop_c   = scl_sync[1] & ~sda_sync[2] & sda_sync[1];
  assign byte_in  = {sh_reg, sda_sync[1]};

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg   <= SI_IDLE;
      bitc_reg <= 3'h0;
      sh_reg   <= 7'h00;
      idx_reg  <= 2'h0;
      rw_reg   <= 1'b0;
      hi_reg   <= 1'b0;
      word_reg <= 16'h0000;
      tx_reg   <= 8'h00;
      sda_oe   <= 1'b0;
      sda_out  <= 1'b0;
      req      <= '0;
    end
    else
    begin
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      if (stop_c)
      begin
        st_reg <= SI_IDLE;
        sda_oe <= 1'b0;
      end
      else if (start_c)
      begin
        st_reg   <= SI_RX;
        bitc_reg <= 3'h0;
        idx_reg  <= 2'h0;
        sda_oe   <= 1'b0;
      end
      else
      begin
        case (st_reg)
          SI_RX:
            if (scl_rise)
            begin
              sh_reg   <= byte_in[6:0];
              bitc_reg <= bitc_reg + 3'h1;
              if (bitc_reg == 3'h7)
              begin
                st_reg <= SI_ACKW;
                case (idx_reg)
                  2'h0:
                  begin
                    rw_reg <= byte_in[0];
                    if (byte_in[7:1] != ADDR)
                      st_reg <= SI_IDLE;
                    else if (byte_in[0])
                    begin
                      word_reg <= rd_data;
                      hi_reg   <= 1'b1;
                      req.rd   <= 1'b1;
                    end
                    idx_reg <= 2'h1;
                  end
                  2'h1:
                  begin
                    req.ptr <= byte_in;
                    idx_reg <= 2'h2;
                  end
                  2'h2:
                  begin
                    req.data[15:8] <= byte_in;
                    idx_reg        <= 2'h3;
                  end
                  default:
                  begin
                    req.data[7:0] <= byte_in;
                    req.wr        <= 1'b1;
                    idx_reg       <= 2'h2;
                  end
                endcase
              end
            end
          SI_ACKW:
            if (scl_fall)
            begin
              sda_oe <= 1'b1;
              st_reg <= SI_ACK;
            end
          SI_ACK:
            if (scl_fall)
            begin
              bitc_reg <= 3'h0;
              if (rw_reg)
              begin
                tx_reg <= word_reg[15:8];
                hi_reg <= 1'b0;
                sda_oe <= ~word_reg[15];
                st_reg <= SI_TX;
              end
              else
              begin
                sda_oe <= 1'b0;
                st_reg <= SI_RX;
              end
            end
          SI_TX:
            if (scl_fall)
            begin
              bitc_reg <= bitc_reg + 3'h1;
              tx_reg   <= {tx_reg[6:0], 1'b0};
              sda_oe   <= (bitc_reg == 3'h7) ? 1'b0 : ~tx_reg[6];
              if (bitc_reg == 3'h7)
                st_reg <= SI_RACK;
            end
          SI_RACK:
            if (scl_rise && sda_sync[1])
              st_reg <= SI_IDLE;
            else if (scl_fall)
            begin
              // words repeat msb then lsb until the master refuses
              tx_reg   <= hi_reg ? word_reg[15:8] : word_reg[7:0];
              sda_oe   <= hi_reg ? ~word_reg[15] : ~word_reg[7];
              hi_reg   <= ~hi_reg;
              bitc_reg <= 3'h0;
              st_reg   <= SI_TX;
            end
          default:
            st_reg <= SI_IDLE;
        endcase
      end
    end
  end

endmodule

// [verilog/light_sensor_ctrl.sv]
// conversion control of the ambient light sensor
//
// Overview of operation
// - range field bits 15:12 select full-scale range
// - code 1100b selects automatic ranging, reported exponent
// - range field resets to automatic code 1100b
// - length bit chooses 100 or 800 ms, reset 1
// - short conversion trims low result bits in ranges 0 to 5
// - result format and step weight stay fixed
// - mode 00 shutdown, 01 single, 1x continuous
// - single-shot mode clears itself when done
// - shutdown leaves ready, high, low flags untouched
// - overflow bit recomputed every measurement
// - manual range may flag transient overload
// - auto range flags overflow only at top
// - auto overflow aborts, raises range, restarts
// - overflow read-only, control fields read-write
// - configuration write aborts, then restarts if asked
// - ready set at end, cleared by config read or converting write
`timescale 1ns/1ps
`include "light_sensor_defines.svh"
module light_sensor_ctrl
  import light_sensor_pkg::*;
#(
  parameter int unsigned SHORT_CYC = `T_SHORT_CYC,
  parameter int unsigned LONG_CYC  = `T_LONG_CYC,
  parameter logic [6:0]  ADDR      = `SLAVE_ADDR
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // two-wire bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe,
  // analog front end
  input  wire logic        fe_overload,
  input  wire logic [11:0] fe_mantissa,
  output      logic        fe_integrate,
  output      logic [3:0]  fe_range,
  output      logic        fe_long,
  // limit flag logic
  input  wire logic        high_flag,
  input  wire logic        low_flag,
  output      logic        conv_end,
  output      logic [4:0]  flag_ctl
);

  reg_req_s    req;
  logic [15:0] rd_data;
  logic        tmr_done;
  logic        wr;
  logic        rd_cfg;
  logic [1:0]  wmode;
  logic [3:0]  wrange;
  logic        auto_m;
  logic        retry;
  logic        eoc;
  conv_state_e st_reg;
  logic [3:0]  rn_reg;
  logic [1:0]  mode_reg;
  logic        ovf_reg;
  logic        crf_reg;
  logic        ovl_reg;
  logic        restart_reg;
  logic [15:0] result_reg;
  localparam logic [15:0] CFG_RST = `CFG_RESET;

  // ----------------------------------------------------------------
  // bus slave and timer
  // ----------------------------------------------------------------
  serial_slave #(
    .ADDR    (ADDR)
  ) u_slave (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .req     (req),
    .rd_data (rd_data)
  );

  conv_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC),
    .CW        (`TMR_W)
  ) u_timer (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .restart   (restart_reg),
    .run       (fe_integrate),
    .long_sel  (fe_long),
    .done      (tmr_done)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign wr     = req.wr && (req.ptr == `OFF_CFG);
  assign rd_cfg = req.rd && (req.ptr == `OFF_CFG);
  assign wmode  = req.data[`CFG_M_MSB:`CFG_M_LSB];
  assign wrange = req.data[`CFG_RN_MSB:`CFG_RN_LSB];
  // reserved codes run as automatic, the safest reading
  assign auto_m = (rn_reg >= `RN_AUTO);
  assign retry  = (st_reg == ST_CONV) && auto_m && fe_overload
               && (fe_range < `RN_MAX) && !wr && !restart_reg;
  assign eoc    = (st_reg == ST_CONV) && tmr_done && !restart_reg
               && !wr && !retry;

  // trims resolution; step weight and format are left alone
  function automatic logic [11:0] trim(input logic [11:0] m,
                                       input logic [3:0]  r,
                                       input logic        long_c);
    logic [11:0] t;
    t = m;
    if (!long_c)
    begin
      if (r == 4'h0)
        t = {m[11:3], 3'h0};
      else if (r <= 4'h4)
        t = {m[11:2], 2'h0};
      else if (r == 4'h5)
        t = {m[11:1], 1'h0};
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rn_reg   <= CFG_RST[`CFG_RN_MSB:`CFG_RN_LSB];
      fe_long  <= CFG_RST[`CFG_CT];
      mode_reg <= CFG_RST[`CFG_M_MSB:`CFG_M_LSB];
      flag_ctl <= CFG_RST[`CFG_AUX_MSB:`CFG_AUX_LSB];
    end
    else if (wr)
    begin
      rn_reg   <= wrange;
      fe_long  <= req.data[`CFG_CT];
      mode_reg <= wmode;
      flag_ctl <= req.data[`CFG_AUX_MSB:`CFG_AUX_LSB];
    end
    else if (eoc && (mode_reg == `MODE_SINGLE))
      mode_reg <= `MODE_SHUT;
  end

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg       <= ST_IDLE;
      fe_integrate <= 1'b0;
      restart_reg  <= 1'b0;
      fe_range     <= 4'h0;
    end
    else
    begin
      restart_reg <= 1'b0;
      if (wr)
      begin
        // auto mode starts from the range it last settled on
        if (wrange < `RN_AUTO)
          fe_range <= wrange;
        if (wmode != `MODE_SHUT)
        begin
          st_reg       <= ST_CONV;
          fe_integrate <= 1'b1;
          restart_reg  <= 1'b1;
        end
        else
        begin
          st_reg       <= ST_IDLE;
          fe_integrate <= 1'b0;
        end
      end
      else if (retry)
      begin
        fe_range    <= fe_range + 4'h1;
        restart_reg <= 1'b1;
      end
      else if (eoc)
      begin
        if (auto_m && (fe_mantissa < `RN_STEPDOWN) && (fe_range != 4'h0))
          fe_range <= fe_range - 4'h1;
        if (mode_reg[1])
          restart_reg <= 1'b1;
        else
        begin
          st_reg       <= ST_IDLE;
          fe_integrate <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // overload capture and result
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ovl_reg <= 1'b0;
    // auto ranging below the top retries instead of flagging
    else if ((st_reg == ST_CONV) && fe_overload
             && !(auto_m && (fe_range < `RN_MAX)))
      ovl_reg <= 1'b1;
    else if (restart_reg)
      ovl_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      result_reg <= 16'h0000;
      ovf_reg    <= 1'b0;
      conv_end   <= 1'b0;
    end
    else
    begin
      conv_end <= eoc;
      if (eoc)
      begin
        result_reg[15:12] <= (flag_ctl[`CFG_ME] && !auto_m) ? 4'h0
                                                              : fe_range;
        result_reg[11:0]  <= trim(fe_mantissa, fe_range, fe_long);
        ovf_reg           <= ovl_reg | fe_overload;
      end
    end
  end

  // set beats clear when both fall in one cycle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      crf_reg <= 1'b0;
    else if (eoc)
      crf_reg <= 1'b1;
    else if (rd_cfg || (wr && (wmode != `MODE_SHUT)))
      crf_reg <= 1'b0;
  end

  always_comb
  begin
    rd_data = 16'h0000;
    if (req.ptr == `OFF_RESULT)
      rd_data = result_reg;
    else if (req.ptr == `OFF_CFG)
      rd_data = {rn_reg, fe_long, mode_reg, ovf_reg, crf_reg,
                 high_flag, low_flag, flag_ctl};
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_single_done;
    @(posedge clk_sys) disable iff (!nrst)
    eoc && (mode_reg == `MODE_SINGLE) |=> (mode_reg == `MODE_SHUT)
                                          && !fe_integrate;
  endproperty
  a_single_done: assert property (p_single_done)
    else $error("single-shot did not return to shutdown");

  property p_write_stop;
    @(posedge clk_sys) disable iff (!nrst)
    wr && (wmode == `MODE_SHUT) |=> (st_reg == ST_IDLE) ##1 !conv_end;
  endproperty
  a_write_stop: assert property (p_write_stop)
    else $error("shutdown write did not abort conversion");

  property p_write_start;
    @(posedge clk_sys) disable iff (!nrst)
    wr && (wmode != `MODE_SHUT) |=> restart_reg && fe_integrate;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("converting write did not restart");

  property p_ready_set;
    @(posedge clk_sys) disable iff (!nrst)
    eoc |=> crf_reg && conv_end;
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("ready bit not set at end of conversion");

  property p_ready_clear;
    @(posedge clk_sys) disable iff (!nrst)
    rd_cfg && !eoc |=> !crf_reg;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("ready bit not cleared by read");

  property p_shut_keeps;
    @(posedge clk_sys) disable iff (!nrst)
    wr && (wmode == `MODE_SHUT) && !eoc |=> crf_reg == $past(crf_reg);
  endproperty
  a_shut_keeps: assert property (p_shut_keeps)
    else $error("shutdown write changed ready bit");

  property p_range_up;
    @(posedge clk_sys) disable iff (!nrst)
    retry |=> (fe_range == $past(fe_range) + 4'h1) && restart_reg;
  endproperty
  a_range_up: assert property (p_range_up)
    else $error("auto overflow did not raise range");

  property p_auto_ovf;
    @(posedge clk_sys) disable iff (!nrst)
    eoc && auto_m && (fe_range != `RN_MAX) |=> !ovf_reg;
  endproperty
  a_auto_ovf: assert property (p_auto_ovf)
    else $error("auto range flagged overflow below top");

  property p_ovf_hold;
    @(posedge clk_sys) disable iff (!nrst)
    !eoc |=> $stable(ovf_reg);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow bit moved outside a measurement end");

  property p_cont_same;
    @(posedge clk_sys) disable iff (!nrst)
    eoc && mode_reg[1] |=> fe_integrate && restart_reg;
  endproperty
  a_cont_same: assert property (p_cont_same)
    else $error("continuous mode did not restart");

endmodule

// [testbench/serial_host.sv]
// two-wire bus host model for the sensor serial port
`timescale 1ns/1ps
module serial_host
#(
  parameter logic [6:0] ADDR = 7'h2a
)
(
  // clock
  input  wire logic clk_sys,
  // bus wires, sda_drv high = released
  output      logic scl,
  output      logic sda_drv,
  input  wire logic sda_w
);
  // ------------------
  // bit level
  // ------------------
  // scl stands high between frames, lines move only at falling edges
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic quarter();
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic start_c();
    sda_drv = 1'b1;
    scl = 1'b1;
    quarter();
    sda_drv = 1'b0;
    quarter();
    scl = 1'b0;
    quarter();
  endtask

  task automatic stop_c();
    sda_drv = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    sda_drv = 1'b1;
    quarter();
  endtask

  // sample late in the high phase: the slave answers via synchronisers
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    quarter();
    scl = 1'b1;
    repeat (3) @(negedge clk_sys);
    r = sda_w;
    @(negedge clk_sys);
    scl = 1'b0;
    quarter();
  endtask

  // ------------------
  // byte and word level
  // ------------------
  task automatic byte_x(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], r[i]);
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [7:0] r;
    logic       a;
    byte_x(b, r);
    bit_x(1'b1, a);
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] v);
    logic a;
    byte_x(8'hff, v);
    bit_x(last, a);
  endtask

  task automatic write_word(input logic [15:0] d);
    if (d[15:12] > 4'hc)
      d[15:12] = 4'hc; // reserved range codes never sent
    start_c();
    send_byte({ADDR, 1'b0});
    send_byte(8'h01);
    send_byte(d[15:8]);
    send_byte(d[7:0]);
    stop_c();
  endtask

  task automatic read_word(input logic [7:0] p, output logic [15:0] d);
    start_c();
    send_byte({ADDR, 1'b0});
    send_byte(p);
    stop_c();
    start_c();
    send_byte({ADDR, 1'b1});
    recv_byte(1'b0, d[15:8]);
    recv_byte(1'b1, d[7:0]);
    stop_c();
  endtask
endmodule

// [testbench/light_sensor_ctrl_tb_top.sv]
// self-checking bench of the light sensor conversion control
`timescale 1ns/1ps
module light_sensor_ctrl_tb_top
  import light_sensor_pkg::*;
;
  // ------------------
  // signals
  // ------------------
  localparam int SC = 1000;
  localparam int LC = 3000;
  logic        clk_sys = 1'b0;
  logic        nrst;
  logic        scl;
  logic        sda_drv;
  logic        sda_w;
  logic        sda_out;
  logic        sda_oe;
  logic        fe_overload;
  logic [11:0] fe_mantissa;
  logic        fe_integrate;
  logic [3:0]  fe_range;
  logic        fe_long;
  logic        high_flag;
  logic        low_flag;
  logic        conv_end;
  logic [4:0]  flag_ctl;
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [15:0] d;
  int          n;
  logic [3:0]  rt[5] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h0};
  logic        ct[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [11:0] mt[5] = '{12'hff8, 12'hffc, 12'hffe, 12'hfff, 12'hfff};

  always #20 clk_sys = ~clk_sys;
  // open-drain wire with pull-up
  assign sda_w = sda_drv & ~sda_oe;

  light_sensor_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC)) DUT
  (
    .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .fe_overload(fe_overload),
    .fe_mantissa(fe_mantissa), .fe_integrate(fe_integrate),
    .fe_range(fe_range), .fe_long(fe_long), .high_flag(high_flag),
    .low_flag(low_flag), .conv_end(conv_end), .flag_ctl(flag_ctl)
  );

  serial_host host
  (
    .clk_sys(clk_sys), .scl(scl), .sda_drv(sda_drv), .sda_w(sda_w)
  );

  // ------------------
  // helpers
  // ------------------
  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_end(output int k);
    k = 0;
    @(negedge clk_sys);
    while (conv_end !== 1'b1 && k < 9000)
    begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  // one single-shot conversion, then fetch the result word
  task automatic shot(input logic [15:0] c, output logic [15:0] r);
    int k;
    host.write_word(c);
    repeat (4) @(negedge clk_sys);
    check(fe_range, c[15:12]);
    check(fe_long, c[11]);
    wait_end(k);
    repeat (2) @(negedge clk_sys);
    check(fe_integrate, 1'b0);
    host.read_word(8'h00, r);
  endtask

  // a hang would stall far beyond the longest expected run
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // ------------------
  // tests
  // ------------------
  initial
  begin
    nrst = 1'b0;
    fe_overload = 1'b0;
    fe_mantissa = 12'hfff;
    high_flag = 1'b0;
    low_flag = 1'b0;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(fe_long, 1'b1);
    host.read_word(8'h01, d);
    check(d, 16'hc810);
    host.read_word(8'h05, d);
    check(d, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      shot({rt[i], ct[i], 2'b01, 9'h010}, d);
      check(d, {rt[i], mt[i]});
    end
    // single shot with a brief overload inside the conversion
    host.write_word(16'h3a10);
    fe_overload = 1'b1;
    repeat (10) @(negedge clk_sys);
    fe_overload = 1'b0;
    host.read_word(8'h01, d);
    check(d[10:9], 2'b01);
    wait_end(n);
    high_flag = 1'b1;
    repeat (3) @(negedge clk_sys);
    host.read_word(8'h01, d);
    check(d, 16'h39d0);
    host.read_word(8'h01, d);
    check(d, 16'h3950);
    shot(16'h3310, d);
    host.write_word(16'h7815);
    host.read_word(8'h01, d);
    check(d, 16'h78d5);
    host.read_word(8'h01, d);
    check(d, 16'h7855);
    check(flag_ctl, 5'h15);
    // automatic range under steady overload
    fe_overload = 1'b1;
    host.write_word(16'hcc10);
    repeat (40) @(negedge clk_sys);
    check(fe_range, 4'hb);
    wait_end(n);
    fe_overload = 1'b0;
    host.read_word(8'h00, d);
    check(d[15:12], 4'hb);
    host.read_word(8'h01, d);
    check(d[8], 1'b1);
    // rewrite mid-conversion must restart the full length
    for (int m = 2; m < 4; m++)
    begin
      host.write_word({4'h3, 1'b1, 2'(m), 9'h010});
      repeat (1000) @(negedge clk_sys);
      host.write_word({4'h3, 1'b1, 2'(m), 9'h010});
      wait_end(n);
      check(16'(n > 2000), 16'h1);
      wait_end(n);
      check(fe_integrate, 1'b1);
    end
    host.write_word(16'h3810);
    repeat (4) @(negedge clk_sys);
    check(fe_integrate, 1'b0);
    // auto single shot from a mid range: no overflow, short trim
    host.write_word(16'hc210);
    wait_end(n);
    host.read_word(8'h00, d);
    check(d, 16'h3ffc);
    host.read_word(8'h01, d);
    check(d[8], 1'b0);
    check(sda_out, 1'b0);
    report_and_stop();
  end
endmodule
